// ---- rtl/tsm_pkg.sv ----
package tsm_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] TSM_OFS_CTRL = 8'h00;
   localparam logic [7:0] TSM_OFS_TXCFG = 8'h04;
   localparam logic [7:0] TSM_OFS_LEDCFG = 8'h08;
   localparam logic [7:0] TSM_OFS_STATUS = 8'h0C;
   // Control register bit positions
   localparam int TSM_BIT_SPEED100 = 0;
   localparam int TSM_BIT_BYPASS = 1;
   localparam int TSM_BIT_TXDIS = 2;
   localparam int TSM_BIT_TXPD = 3;
   localparam int TSM_BIT_STP = 4;
   // Transmit config fields
   localparam int TSM_POS_GAIN = 0;
   localparam int TSM_POS_EDGE = 4;
   // Reset values
   localparam logic [4:0] TSM_RST_CTRL = 5'h01;
   localparam logic [3:0] TSM_RST_GAIN = 4'h8;
   localparam logic [1:0] TSM_RST_EDGE = 2'h1;
   localparam logic [5:0] TSM_RST_LEDSEL = 6'h00;
   localparam logic [10:0] TSM_RST_SEED = 11'h7FF;
   // Timing
   localparam int TSM_CLK_MHZ = 100;
   localparam int TSM_SYM_DIV = 4;
   localparam int TSM_IDLE_RUN = 25;
   localparam int TSM_SYNC_RUN = 60;
   localparam int TSM_LOCK_WIN_US = 1000;
   localparam int TSM_LED_MS = 100;
   localparam int TSM_LOCK_WIN_CYC = TSM_LOCK_WIN_US * TSM_CLK_MHZ;
   localparam int TSM_LED_CYC = TSM_LED_MS * 1000 * TSM_CLK_MHZ;
   // MLT-3 levels
   localparam logic [1:0] TSM_LVL_ZERO = 2'h0;
   localparam logic [1:0] TSM_LVL_POS = 2'h1;
   localparam logic [1:0] TSM_LVL_NEG = 2'h2;
   // Descrambler lock state
   typedef enum logic [1:0] {
      TSM_ST_HUNT = 2'b01,
      TSM_ST_LOCK = 2'b10
   } tsm_lock_e;
endpackage

// ---- rtl/tsm_line_path.sv ----
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// R1: Scramble 5B stream at 100 Mbps
// R2: No scrambling or descrambling at 10
// R3: Bypass bit passes transmit symbols unchanged
// R4: Bypass bit passes receive data undescrambled
// R5: Descramble and align to 5B boundaries
// R6: Need 25 idle ones per 1 ms
// R7: Missed window drops lock, restarts acquisition
// R8: Loss-of-lock status set while unsynchronized
// R9: MLT-3: one steps level, zero holds
// R10: Four-bit gain code, 0000 highest gain
// R11: Two-bit edge-rate adjust field
// R12: Cable type bit selects 150 ohm mode
// R13: Activity LEDs low 100 ms per packet
// R14: Transmit disable forces idle, loopback off
// R15: Powerdown tristates line, rest runs
// R16: At 10 Mbps, idle line only pulses
// R17: Decode MLT-3 comparators to bit stream
// R18: 10 Mbps squelch gates zero-crossing data
// R19: x^11+x^9+1 key, seeded from idle
// R20: Config applies on next bit
module tsm_line_path
   import tsm_pkg::*;
#(
   parameter int LOCK_WIN_CYC = TSM_LOCK_WIN_CYC,
   parameter int LED_CYC = TSM_LED_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic tx_bit,
   input wire logic tx_pkt_start,
   input wire logic tx_link_pulse,
   input wire logic rx_cmp_pos,
   input wire logic rx_cmp_neg,
   input wire logic rx_squelch_ok,
   input wire logic rx_zero_cross,
   output logic [1:0] tx_mlt3_level,
   output logic tx_line_oe,
   output logic [3:0] tx_gain_code,
   output logic [1:0] tx_edge_adj,
   output logic tx_stp_mode,
   output logic tx_loopback_en,
   output logic [4:0] rx_symbol,
   output logic rx_symbol_valid,
   output logic rx_bit10,
   output logic rx_lock_lost,
   output logic [5:0] programmable_led_outputs
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
      end
      else
      begin
         pin_s1 <= {rx_cmp_pos, rx_cmp_neg, rx_squelch_ok, rx_zero_cross, tx_pkt_start};
         pin_s2 <= pin_s1;
      end
   end
   logic cmp_pos, cmp_neg, sq_ok, zc, pkt_start;
   assign {cmp_pos, cmp_neg, sq_ok, zc, pkt_start} = pin_s2;

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic [4:0] ctrl;
   logic [3:0] gain;
   logic [1:0] edge_adj;
   logic [5:0] led_sel;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic lock_lost;
   wire addr_ok = hsel && hready && htrans[1];
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= TSM_RST_CTRL;
         gain <= TSM_RST_GAIN;
         edge_adj <= TSM_RST_EDGE;
         led_sel <= TSM_RST_LEDSEL;
      end
      else if (wr_pend)
      begin
         if (wr_addr == TSM_OFS_CTRL)
            ctrl <= hwdata[4:0];
         if (wr_addr == TSM_OFS_TXCFG)
         begin
            gain <= hwdata[TSM_POS_GAIN +: 4];
            edge_adj <= hwdata[TSM_POS_EDGE +: 2];
         end
         if (wr_addr == TSM_OFS_LEDCFG)
            led_sel <= hwdata[5:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
      begin
         unique case (haddr[7:0])
            TSM_OFS_CTRL: hrdata <= {27'h0, ctrl};
            TSM_OFS_TXCFG: hrdata <= {26'h0, edge_adj, gain};
            TSM_OFS_LEDCFG: hrdata <= {26'h0, led_sel};
            TSM_OFS_STATUS: hrdata <= {31'h0, lock_lost};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // Symbol bit-rate enable
   // ----------------------------------------
   logic [1:0] div_cnt;
   logic bit_en;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_cnt <= 2'h0;
         bit_en <= 1'b0;
      end
      else
      begin
         div_cnt <= (div_cnt == 2'(TSM_SYM_DIV - 1)) ? 2'h0 : div_cnt + 2'h1;
         bit_en <= (div_cnt == 2'(TSM_SYM_DIV - 1));
      end
   end

   // Config sampled per bit
   logic spd100, bypass, txdis, txpd;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         spd100 <= TSM_RST_CTRL[TSM_BIT_SPEED100];
         bypass <= 1'b0;
         txdis <= 1'b0;
         txpd <= 1'b0;
         tx_gain_code <= TSM_RST_GAIN;
         tx_edge_adj <= TSM_RST_EDGE;
         tx_stp_mode <= 1'b0;
         tx_loopback_en <= 1'b1;
      end
      else if (bit_en)
      begin
         spd100 <= ctrl[TSM_BIT_SPEED100]; // R20
         bypass <= ctrl[TSM_BIT_BYPASS];
         txdis <= ctrl[TSM_BIT_TXDIS];
         txpd <= ctrl[TSM_BIT_TXPD];
         tx_gain_code <= gain; // R10
         tx_edge_adj <= edge_adj; // R11
         tx_stp_mode <= ctrl[TSM_BIT_STP]; // R12
         tx_loopback_en <= !ctrl[TSM_BIT_TXDIS]; // R14
      end
   end

   // ----------------------------------------
   // Transmit scrambler and MLT-3
   // ----------------------------------------
   logic [10:0] tx_key;
   logic [1:0] mlt_lvl;
   logic mlt_up;
   wire tx_key_bit = tx_key[10] ^ tx_key[8]; // R19
   logic tx_nrz;
   always_comb
   begin
      if (!spd100)
         tx_nrz = tx_link_pulse; // R2 R16
      else if (bypass)
         tx_nrz = tx_bit; // R3
      else
         tx_nrz = tx_bit ^ tx_key_bit; // R1
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_key <= TSM_RST_SEED;
      else if (bit_en && spd100)
         tx_key <= {tx_key[9:0], tx_key_bit};
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mlt_lvl <= TSM_LVL_ZERO;
         mlt_up <= 1'b1;
      end
      else if (bit_en && !txdis && tx_nrz) // R9 R14
      begin
         unique case (mlt_lvl)
            TSM_LVL_ZERO: mlt_lvl <= mlt_up ? TSM_LVL_POS : TSM_LVL_NEG;
            TSM_LVL_POS: mlt_lvl <= TSM_LVL_ZERO;
            default: mlt_lvl <= TSM_LVL_ZERO;
         endcase
         if (mlt_lvl != TSM_LVL_ZERO)
            mlt_up <= (mlt_lvl == TSM_LVL_NEG);
      end
      else if (bit_en && txdis)
         mlt_lvl <= TSM_LVL_ZERO; // R14
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         tx_mlt3_level <= TSM_LVL_ZERO;
         tx_line_oe <= 1'b0;
      end
      else
      begin
         tx_mlt3_level <= mlt_lvl;
         tx_line_oe <= !txpd; // R15
      end
   end

   // ----------------------------------------
   // Receive MLT-3 decode and descrambler
   // ----------------------------------------
   logic [1:0] rx_prev;
   wire [1:0] rx_lvl = cmp_pos ? TSM_LVL_POS : (cmp_neg ? TSM_LVL_NEG : TSM_LVL_ZERO);
   wire rx_nrz = (rx_lvl != rx_prev); // R17
   logic [10:0] rx_key;
   wire rx_key_bit = rx_key[10] ^ rx_key[8];
   tsm_lock_e lock_st;
   logic [5:0] run;
   logic [16:0] win;
   logic win_ok;
   logic [2:0] bitpos;
   logic [4:0] sh;
   wire descr = (lock_st == TSM_ST_LOCK) ? (rx_nrz ^ rx_key_bit) : 1'b1;
   wire rx_out = bypass ? rx_nrz : descr; // R4
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rx_prev <= TSM_LVL_ZERO;
         rx_key <= TSM_RST_SEED;
         lock_st <= TSM_ST_HUNT;
         run <= 6'h00;
         win <= 17'h0;
         win_ok <= 1'b0;
      end
      else if (bit_en && spd100 && !bypass) // R2
      begin
         rx_prev <= rx_lvl;
         unique case (lock_st)
            TSM_ST_HUNT:
            begin
               rx_key <= {rx_key[9:0], ~rx_nrz}; // R19
               run <= ((rx_nrz ^ rx_key_bit) == 1'b1) ? run + 6'h1 : 6'h00;
               if (run == 6'(TSM_SYNC_RUN))
               begin
                  lock_st <= TSM_ST_LOCK;
                  run <= 6'h00;
                  win <= 17'h0;
                  win_ok <= 1'b0;
               end
            end
            TSM_ST_LOCK:
            begin
               rx_key <= {rx_key[9:0], rx_key_bit};
               run <= descr ? run + 6'h1 : 6'h00;
               if (descr && run >= 6'(TSM_IDLE_RUN - 1))
                  win_ok <= 1'b1; // R6
               win <= win + 17'h4;
               if (win >= 17'(LOCK_WIN_CYC - 4))
               begin
                  win <= 17'h0;
                  win_ok <= 1'b0;
                  if (!win_ok)
                  begin
                     lock_st <= TSM_ST_HUNT; // R7
                     run <= 6'h00;
                  end
               end
            end
         endcase
      end
      else if (bit_en)
         rx_prev <= rx_lvl;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lock_lost <= 1'b1;
      else
         lock_lost <= (lock_st != TSM_ST_LOCK); // R8
   end
   // Word alignment: idle words stream, idle-to-J edge realigns framing
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sh <= 5'h1F;
         bitpos <= 3'h0;
         rx_symbol <= 5'h1F;
         rx_symbol_valid <= 1'b0;
      end
      else
      begin
         rx_symbol_valid <= 1'b0;
         if (bit_en && spd100 && (bypass || lock_st == TSM_ST_LOCK))
         begin
            sh <= {sh[3:0], rx_out};
            if (bitpos == 3'h4 || {sh, rx_out} == 6'h38) // R5
            begin
               bitpos <= 3'h0;
               rx_symbol <= {sh[3:0], rx_out};
               rx_symbol_valid <= 1'b1;
            end
            else
               bitpos <= bitpos + 3'h1;
         end
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rx_bit10 <= 1'b0;
      else
         rx_bit10 <= !spd100 && sq_ok && zc; // R18
   end
   assign rx_lock_lost = lock_lost;

   // ----------------------------------------
   // Activity LEDs
   // ----------------------------------------
   logic [31:0] led_cnt;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         led_cnt <= 32'h0;
         programmable_led_outputs <= 6'h3F;
      end
      else
      begin
         if (pkt_start)
            led_cnt <= 32'(LED_CYC); // R13
         else if (led_cnt != 32'h0)
            led_cnt <= led_cnt - 32'h1;
         programmable_led_outputs <= (led_cnt != 32'h0 || pkt_start) ? ~led_sel : 6'h3F;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_lock_flag;
      @(posedge hclk) disable iff (!hresetn)
      (lock_st == TSM_ST_HUNT) |=> rx_lock_lost;
   endproperty
   a_lock_flag: assert property (p_lock_flag) else $error("lock flag low while hunting"); // R8
   property p_pd;
      @(posedge hclk) disable iff (!hresetn)
      txpd |=> !tx_line_oe;
   endproperty
   a_pd: assert property (p_pd) else $error("line driven in powerdown"); // R15
   property p_led;
      @(posedge hclk) disable iff (!hresetn)
      (pkt_start && led_sel[0]) |=> !programmable_led_outputs[0] [*8];
   endproperty
   a_led: assert property (p_led) else $error("led not asserted"); // R13
   sequence s_line_idle;
      ##1 (tx_mlt3_level == TSM_LVL_ZERO);
   endsequence
   property p_txdis;
      @(posedge hclk) disable iff (!hresetn)
      (bit_en && txdis) |=> s_line_idle;
   endproperty
   a_txdis: assert property (p_txdis) else $error("line not idle when disabled"); // R14
   property p_sym;
      @(posedge hclk) disable iff (!hresetn)
      rx_symbol_valid |=> !rx_symbol_valid;
   endproperty
   a_sym: assert property (p_sym) else $error("symbol valid longer than one cycle"); // R5
   property p_gain;
      @(posedge hclk) disable iff (!hresetn)
      bit_en |=> (tx_gain_code == $past(gain));
   endproperty
   a_gain: assert property (p_gain) else $error("gain code not applied"); // R10
endmodule

// ---- bench/tsm_link_partner.sv ----
`timescale 1ns/1ps
module tsm_link_partner
   import tsm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic send_en,
   input wire logic scram_en,
   input wire logic clr,
   input wire logic [1:0] tx_mlt3_level,
   output logic rx_cmp_pos,
   output logic rx_cmp_neg,
   output logic [15:0] changes,
   output logic [15:0] bad_steps
);
   logic [1:0] div;
   logic [10:0] key;
   logic [1:0] lvl;
   logic neg_next;
   logic [1:0] prev;
   logic [1:0] last_nz;
   logic bitv;
   logic bad;
   // ----------------------------------------
   // Idle stream sender
   // ----------------------------------------
   assign bitv = 1'b1 ^ (scram_en & (key[10] ^ key[8]));
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div <= 2'h0;
         key <= 11'h7FF;
         lvl <= TSM_LVL_ZERO;
         neg_next <= 1'b0;
      end
      else
      begin
         div <= div + 2'h1;
         if (div == 2'h3)
         begin
            key <= {key[9:0], key[10] ^ key[8]};
            if (!send_en)
               lvl <= TSM_LVL_ZERO;
            else if (bitv && lvl != TSM_LVL_ZERO)
               lvl <= TSM_LVL_ZERO;
            else if (bitv)
            begin
               lvl <= neg_next ? TSM_LVL_NEG : TSM_LVL_POS;
               neg_next <= ~neg_next;
            end
         end
      end
   end
   assign rx_cmp_pos = (lvl == TSM_LVL_POS);
   assign rx_cmp_neg = (lvl == TSM_LVL_NEG);
   // ----------------------------------------
   // Line monitor
   // ----------------------------------------
   assign bad = (prev != TSM_LVL_ZERO && tx_mlt3_level != TSM_LVL_ZERO)
      || (prev == TSM_LVL_ZERO && tx_mlt3_level == last_nz) || tx_mlt3_level == 2'h3;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prev <= TSM_LVL_ZERO;
         last_nz <= TSM_LVL_ZERO;
         changes <= 16'h0;
         bad_steps <= 16'h0;
      end
      else
      begin
         prev <= tx_mlt3_level;
         if (tx_mlt3_level != TSM_LVL_ZERO)
            last_nz <= tx_mlt3_level;
         if (clr)
         begin
            changes <= 16'h0;
            bad_steps <= 16'h0;
         end
         else if (tx_mlt3_level != prev)
         begin
            changes <= changes + 16'h1;
            bad_steps <= bad_steps + {15'h0, bad};
         end
      end
   end
endmodule

// ---- bench/tsm_line_path_bench.sv ----
`timescale 1ns/1ps
module tsm_line_path_bench;
   import tsm_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic tx_bit = 1'b0;
   logic tx_pkt_start = 1'b0;
   logic tx_link_pulse = 1'b0;
   logic rx_squelch_ok = 1'b0;
   logic rx_zero_cross = 1'b0;
   logic send_en = 1'b0;
   logic scram_en = 1'b0;
   logic clr = 1'b0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, tx_line_oe, tx_stp_mode, tx_loopback_en;
   logic rx_cmp_pos, rx_cmp_neg, rx_symbol_valid, rx_bit10, rx_lock_lost;
   logic [1:0] tx_mlt3_level, tx_edge_adj;
   logic [3:0] tx_gain_code, g;
   logic [4:0] rx_symbol;
   logic [5:0] programmable_led_outputs;
   logic [15:0] changes, bad_steps;
   int errors = 0;
   int cmp_count = 0;

   always #5 hclk = ~hclk;

   tsm_line_path #(.LOCK_WIN_CYC(400), .LED_CYC(50)) tsm_line_path_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .tx_bit(tx_bit), .tx_pkt_start(tx_pkt_start),
      .tx_link_pulse(tx_link_pulse), .rx_cmp_pos(rx_cmp_pos), .rx_cmp_neg(rx_cmp_neg),
      .rx_squelch_ok(rx_squelch_ok), .rx_zero_cross(rx_zero_cross),
      .tx_mlt3_level(tx_mlt3_level), .tx_line_oe(tx_line_oe), .tx_gain_code(tx_gain_code),
      .tx_edge_adj(tx_edge_adj), .tx_stp_mode(tx_stp_mode), .tx_loopback_en(tx_loopback_en),
      .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid), .rx_bit10(rx_bit10),
      .rx_lock_lost(rx_lock_lost), .programmable_led_outputs(programmable_led_outputs));

   tsm_link_partner tsm_link_partner_inst (.hclk(hclk), .hresetn(hresetn),
      .send_en(send_en), .scram_en(scram_en), .clr(clr), .tx_mlt3_level(tx_mlt3_level),
      .rx_cmp_pos(rx_cmp_pos), .rx_cmp_neg(rx_cmp_neg), .changes(changes),
      .bad_steps(bad_steps));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task finish_test;
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task hang;
      errors++;
      $display("[ERR] %0t wait timed out", $time);
      finish_test;
   endtask

   task rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 100);
      if (hreadyout !== 1'b1)
         hang;
   endtask

   task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy;
      rd = hrdata;
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task waitv(input int which, input logic v, input int lim);
      int n;
      n = 0;
      while ((which == 0 ? rx_lock_lost : rx_symbol_valid) !== v && n < lim)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= lim)
         hang;
   endtask

   task run(input logic [31:0] ctrl, input logic b, input int n);
      bus(TSM_OFS_CTRL, 1'b1, ctrl);
      tx_bit <= b;
      repeat (20) @(posedge hclk);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (n) @(posedge hclk);
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(hresp, 0);
      chk(rx_lock_lost, 1);
      chk(programmable_led_outputs, 6'h3F);
      rchk(TSM_OFS_CTRL, TSM_RST_CTRL);
      rchk(TSM_OFS_TXCFG, {TSM_RST_EDGE, TSM_RST_GAIN});
      rchk(TSM_OFS_LEDCFG, TSM_RST_LEDSEL);
      rchk(TSM_OFS_STATUS, 1);
      bus(8'h10, 1'b1, 32'hFFFFFFFF);
      rchk(8'h10, 0);
      run(3, 1, 41);
      chk(changes, 10);
      chk(bad_steps, 0);
      run(3, 0, 41);
      chk(changes, 0);
      run(1, 0, 81);
      chk(changes != 0, 1);
      run(1, 1, 81);
      chk(changes < 20, 1);
      chk(bad_steps, 0);
      run(0, 1, 41);
      chk(changes, 0);
      chk(tx_line_oe, 1);
      tx_link_pulse <= 1'b1;
      run(7, 1, 41);
      chk(changes, 0);
      chk(tx_loopback_en, 0);
      tx_link_pulse <= 1'b0;
      run(32'hB, 1, 41);
      chk(tx_line_oe, 0);
      rchk(TSM_OFS_CTRL, 32'hB);
      for (int i = 0; i < 16; i++)
      begin
         g = i[3:0];
         bus(TSM_OFS_TXCFG, 1'b1, {26'h0, g[1:0], g});
         repeat (12) @(posedge hclk);
         chk(tx_gain_code, g);
         chk(tx_edge_adj, g[1:0]);
      end
      bus(TSM_OFS_CTRL, 1'b1, 32'h11);
      repeat (12) @(posedge hclk);
      chk(tx_stp_mode, 1);
      bus(TSM_OFS_LEDCFG, 1'b1, 32'h5);
      tx_pkt_start <= 1'b1;
      @(posedge hclk);
      tx_pkt_start <= 1'b0;
      repeat (10) @(posedge hclk);
      chk(programmable_led_outputs, 6'h3A);
      repeat (60) @(posedge hclk);
      chk(programmable_led_outputs, 6'h3F);
      bus(TSM_OFS_CTRL, 1'b1, 32'h1);
      send_en <= 1'b1;
      scram_en <= 1'b1;
      waitv(0, 0, 3000);
      rchk(TSM_OFS_STATUS, 0);
      repeat (1200) @(posedge hclk);
      chk(rx_lock_lost, 0);
      waitv(1, 1, 100);
      chk(rx_symbol, 5'h1F);
      send_en <= 1'b0;
      waitv(0, 1, 900);
      rchk(TSM_OFS_STATUS, 1);
      bus(TSM_OFS_CTRL, 1'b1, 32'h3);
      scram_en <= 1'b0;
      send_en <= 1'b1;
      repeat (200) @(posedge hclk);
      waitv(1, 1, 100);
      chk(rx_symbol, 5'h1F);
      bus(TSM_OFS_CTRL, 1'b1, 32'h0);
      rx_squelch_ok <= 1'b1;
      rx_zero_cross <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(rx_bit10, 1);
      rx_zero_cross <= 1'b0;
      repeat (8) @(posedge hclk);
      chk(rx_bit10, 0);
      rx_squelch_ok <= 1'b0;
      rx_zero_cross <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(rx_bit10, 0);
      finish_test;
   end
endmodule
